// [core/pief_pkg.sv]
// Package of the interrupt enable and flag block.
// Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
package pief_pkg;
    // --------------------------------------------------------------
    // Register indices and byte addresses
    // --------------------------------------------------------------
    // Some printed offsets are not multiples of four, so each offset is an
    // index and the byte address is four times it.
    localparam logic [11:0] IDX_FLAGS_TWO = 12'h00D;
    localparam logic [11:0] IDX_ENABLES_ONE = 12'h08C;
    localparam logic [11:0] IDX_GIC_HOME = 12'h10B;
    localparam logic [11:0] IDX_GIC_MIR0 = 12'h00B;
    localparam logic [11:0] IDX_GIC_MIR1 = 12'h08B;
    localparam logic [11:0] IDX_GIC_MIR3 = 12'h18B;
    localparam logic [11:0] IDX_FLAGS_ONE = 12'h00C;
    localparam logic [11:0] IDX_EVT_STATUS = 12'h200;
    localparam logic [11:0] IDX_EVT_CLEAR = 12'h201;
    localparam logic [11:0] IDX_EVT_ENABLE = 12'h202;
    localparam logic [11:0] IDX_RESET_CTRL = 12'h203;
    localparam int ADDR_W = 14;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int GIC_GLOBAL = 7;
    localparam int GIC_PERIPH = 6;
    localparam int GIC_T0_EN = 5;
    localparam int GIC_EXT_EN = 4;
    localparam int GIC_PC_EN = 3;
    localparam int GIC_T0_FL = 2;
    localparam int GIC_EXT_FL = 1;
    localparam int GIC_PC_FL = 0;
    localparam int F2_LOWV = 7;
    localparam int F2_BCOL = 3;
    localparam int F2_CC2 = 0;
    localparam logic [7:0] F2_MASK = 8'h89;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] GIC_KEEP_MASK = 8'h01;
    localparam int N_EVT = 4;
    localparam logic [N_EVT-1:0] RST_EVT = 4'h0;
endpackage

// [core/pief_evt_if.sv]
// Interface carrying event pulses into the sticky-status unit.
// Assumes both ends share mclk.
`timescale 1ns/1ps
`default_nettype none
interface pief_evt_if #(parameter int N = 4);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] status;
    modport src (output set, output clr, input status);
    modport dst (input set, input clr, output status);
endinterface
`default_nettype wire

// [core/pief_evt_status.sv]
// Sticky event status with write-one-to-clear.
// Assumes single-cycle event pulses on mclk.
`timescale 1ns/1ps
`default_nettype none
module pief_evt_status #(parameter int N = 4) (
    input wire logic mclk,
    input wire logic rst_n,
    pief_evt_if.dst evt
);
    typedef struct packed {
        logic [N-1:0] status;
    } pief_st_t;
    pief_st_t st_r;
    pief_st_t st_nxt;

    // Set wins over clear so no event is lost.
    always_comb begin
        st_nxt = st_r;
        st_nxt.status = (st_r.status & ~evt.clr) | evt.set;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt.status = st_r.status;
endmodule
`default_nettype wire

// [core/pief_top.sv]
// Interrupt enable and flag registers with core request generation.
// Assumes an AHB-Lite master on mclk and event pulses from peripherals
// on the same clock.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module pief_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic warm_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] periph_flags_one,
    input wire logic timer_zero_evt,
    input wire logic external_pin_evt,
    input wire logic port_change_evt,
    input wire logic low_voltage_evt,
    input wire logic bus_collision_evt,
    input wire logic capcomp_two_evt,
    output logic core_irq,
    output logic irq
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] gic;
        logic [7:0] en_one;
        logic [7:0] flags_two;
        logic [3:0] evt_en;
        logic wr_pend;
        logic [11:0] wr_idx;
        logic [31:0] rdata;
        logic core_irq;
        logic irq;
    } pief_state_t;

    pief_state_t s_r;
    pief_state_t s_nxt;
    logic [3:0] evt_set;
    logic [3:0] evt_clr;
    logic [3:0] evt_status;
    logic [7:0] fl1_s1_r;
    logic [7:0] fl1_s2_r;
    logic [5:0] ev_s1_r;
    logic [5:0] ev_s2_r;
    logic [5:0] ev_s3_r;
    logic [5:0] ev_rise;
    logic addr_ok;
    logic [11:0] a_idx;
    logic [31:0] rd_val;

    pief_evt_if #(.N(pief_pkg::N_EVT)) evt_bus ();

    pief_evt_status #(.N(pief_pkg::N_EVT)) u_evt (
        .mclk(mclk),
        .rst_n(rst_n),
        .evt(evt_bus.dst)
    );

    assign evt_bus.set = evt_set;
    assign evt_bus.clr = evt_clr;
    assign evt_status = evt_bus.status;

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    function automatic logic is_gic(input logic [11:0] idx);
        is_gic = (idx == pief_pkg::IDX_GIC_HOME) ||
                 (idx == pief_pkg::IDX_GIC_MIR0) ||
                 (idx == pief_pkg::IDX_GIC_MIR1) ||
                 (idx == pief_pkg::IDX_GIC_MIR3);
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Events come from pins or other logic; they are synchronised and
    // turned into one-cycle pulses on their rising edge.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fl1_s1_r <= 8'h00;
            fl1_s2_r <= 8'h00;
            ev_s1_r <= 6'h00;
            ev_s2_r <= 6'h00;
            ev_s3_r <= 6'h00;
        end else begin
            fl1_s1_r <= periph_flags_one;
            fl1_s2_r <= fl1_s1_r;
            ev_s1_r <= {timer_zero_evt, external_pin_evt, port_change_evt,
                        low_voltage_evt, bus_collision_evt, capcomp_two_evt};
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
        end
    end

    assign ev_rise = ev_s2_r & ~ev_s3_r;
    assign a_idx = haddr[pief_pkg::ADDR_W-1:2];
    assign addr_ok = hsel && htrans[1] && hready;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        evt_clr = 4'h0;
        rd_val = 32'h0000_0000;
        s_nxt.wr_pend = 1'b0;
        // Software writes land in the data phase.
        if (s_r.wr_pend) begin
            if (is_gic(s_r.wr_idx)) begin
                s_nxt.gic = hwdata[7:0];
            end else if (s_r.wr_idx == pief_pkg::IDX_ENABLES_ONE) begin
                s_nxt.en_one = hwdata[7:0];
            end else if (s_r.wr_idx == pief_pkg::IDX_FLAGS_TWO) begin
                s_nxt.flags_two = hwdata[7:0] & pief_pkg::F2_MASK;
            end else if (s_r.wr_idx == pief_pkg::IDX_EVT_CLEAR) begin
                evt_clr = hwdata[3:0];
            end else if (s_r.wr_idx == pief_pkg::IDX_EVT_ENABLE) begin
                s_nxt.evt_en = hwdata[3:0];
            end
        end
        // Hardware set wins over a software write in the same cycle.
        s_nxt.gic[pief_pkg::GIC_T0_FL] = s_nxt.gic[pief_pkg::GIC_T0_FL] |
                                         ev_rise[5];
        s_nxt.gic[pief_pkg::GIC_EXT_FL] = s_nxt.gic[pief_pkg::GIC_EXT_FL] |
                                          ev_rise[4];
        s_nxt.gic[pief_pkg::GIC_PC_FL] = s_nxt.gic[pief_pkg::GIC_PC_FL] |
                                         ev_rise[3];
        s_nxt.flags_two[pief_pkg::F2_LOWV] =
            s_nxt.flags_two[pief_pkg::F2_LOWV] | ev_rise[2];
        s_nxt.flags_two[pief_pkg::F2_BCOL] =
            s_nxt.flags_two[pief_pkg::F2_BCOL] | ev_rise[1];
        s_nxt.flags_two[pief_pkg::F2_CC2] =
            s_nxt.flags_two[pief_pkg::F2_CC2] | ev_rise[0];
        // Global control, enables one and flags two reads see a write landing and a flag set in this same cycle.
        if (is_gic(a_idx)) begin
            rd_val = {24'h000000, s_nxt.gic};
        end else if (a_idx == pief_pkg::IDX_ENABLES_ONE) begin
            rd_val = {24'h000000, s_nxt.en_one};
        end else if (a_idx == pief_pkg::IDX_FLAGS_TWO) begin
            rd_val = {24'h000000, s_nxt.flags_two & pief_pkg::F2_MASK};
        end else if (a_idx == pief_pkg::IDX_FLAGS_ONE) begin
            rd_val = {24'h000000, fl1_s2_r};
        end else if (a_idx == pief_pkg::IDX_EVT_STATUS) begin
            rd_val = {28'h0000000, evt_status};
        end else if (a_idx == pief_pkg::IDX_EVT_ENABLE) begin
            rd_val = {28'h0000000, s_r.evt_en};
        end
        if (addr_ok) begin
            s_nxt.wr_pend = hwrite;
            s_nxt.wr_idx = a_idx;
            s_nxt.rdata = hwrite ? 32'h0000_0000 : rd_val;
        end
        s_nxt.core_irq = s_r.gic[pief_pkg::GIC_GLOBAL] &&
            ((s_r.gic[pief_pkg::GIC_T0_EN] && s_r.gic[pief_pkg::GIC_T0_FL]) ||
             (s_r.gic[pief_pkg::GIC_EXT_EN] && s_r.gic[pief_pkg::GIC_EXT_FL]) ||
             (s_r.gic[pief_pkg::GIC_PC_EN] && s_r.gic[pief_pkg::GIC_PC_FL]) ||
             (s_r.gic[pief_pkg::GIC_PERIPH] &&
              (|(s_r.en_one & fl1_s2_r))));
        s_nxt.irq = |(evt_status & s_r.evt_en);
        // The warm reset keeps the port-change flag, enables one and flags
        // two, because software may still need to see what was pending.
        if (warm_rst) begin
            s_nxt = '0;
            s_nxt.gic = s_r.gic & pief_pkg::GIC_KEEP_MASK;
            s_nxt.en_one = s_r.en_one;
            s_nxt.flags_two = s_r.flags_two;
        end
    end

    // Status events: core request rising, and the three global flags.
    assign evt_set = {s_nxt.core_irq & ~s_r.core_irq, ev_rise[5:3]};

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign core_irq = s_r.core_irq;
    assign irq = s_r.irq;
endmodule
`default_nettype wire

// [bench/pief_properties.sv]
// Checker for pief_top, bound to it from the foot of this file.
// Assumes it sees only the top ports and a zero-wait bus.
`timescale 1ns/1ps
`default_nettype none
module pief_properties (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic warm_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic core_irq,
    input wire logic irq
);
    // ----------------------------------------------------------------
    // Shadow of the global control enables
    // ----------------------------------------------------------------
    // Any mirror may be written, so only the bank-free bits are decoded.
    logic acc, gsel, rd_g, rd_f2, rd_e, wr_r;
    logic [4:0] gsh_r;
    assign acc = hsel & htrans[1] & hready;
    assign gsel = haddr[31:11] == 21'h000000 && haddr[8:0] == 9'h02C;
    assign rd_g = acc & !hwrite & gsel;
    assign rd_f2 = acc & !hwrite & (haddr == 32'h00000034);
    assign rd_e = acc & !hwrite & (haddr == 32'h00000230);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_r <= 1'b0;
            gsh_r <= 5'h00;
        end else begin
            wr_r <= acc & hwrite & gsel;
            gsh_r <= warm_rst ? 5'h00 : (wr_r ? hwdata[7:3] : gsh_r);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_rst_quiet;
        $rose(rst_n) |-> !core_irq && !irq;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("irq after reset");
    property p_warm_drop;
        warm_rst |-> ##2 !core_irq;
    endproperty
    a_warm_drop: assert property (p_warm_drop)
        else $error("warm irq");
    property p_gie_gate;
        !gsh_r[4] && !$past(gsh_r[4]) |-> !core_irq;
    endproperty
    a_gie_gate: assert property (p_gie_gate)
        else $error("no global");
    property p_peripheral_irq_enable;
        gsh_r[3:0] == 4'h0 && $past(gsh_r[3:0]) == 4'h0 |-> !core_irq;
    endproperty
    a_peripheral_irq_enable: assert property (p_peripheral_irq_enable)
        else $error("no periph enable");
    property p_f2_resv;
        rd_f2 |=> (hrdata & 32'hFFFFFF76) == 32'h0;
    endproperty
    a_f2_resv: assert property (p_f2_resv)
        else $error("flag bits");
    property p_g_up;
        rd_g |=> hrdata[31:8] == 24'h0;
    endproperty
    a_g_up: assert property (p_g_up)
        else $error("control width");
    property p_mirror;
        rd_g |=> hrdata[7:3] == gsh_r || hrdata[7:3] == $past(gsh_r);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirror data");
    property p_e_up;
        rd_e |=> hrdata[31:8] == 24'h0;
    endproperty
    a_e_up: assert property (p_e_up)
        else $error("enable width");
endmodule
bind pief_top pief_properties i_props (.mclk(mclk), .rst_n(rst_n),
    .warm_rst(warm_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .core_irq(core_irq), .irq(irq));
`default_nettype wire

// [bench/pief_tb_top.sv]
// Testbench for pief_top, driving the register bus and event pins.
// Assumes a zero-wait slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module pief_tb_top;
    // ----------------------------------------------------------------
    // Bench
    // ----------------------------------------------------------------
    localparam logic [31:0] A_F2 = 32'h34, A_E1 = 32'h230, A_G = 32'h42C;
    logic mclk, rst_n, warm_rst, hsel, hwrite, hrdy, hresp, core_irq, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] pf1;
    logic [5:0] ev;
    int err_count = 0;
    int total_checks = 0;
    pief_top i_dut (.mclk(mclk), .rst_n(rst_n), .warm_rst(warm_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(hresp), .periph_flags_one(pf1),
        .port_change_evt(ev[0]), .external_pin_evt(ev[1]),
        .timer_zero_evt(ev[2]), .low_voltage_evt(ev[3]),
        .bus_collision_evt(ev[4]), .capcomp_two_evt(ev[5]),
        .core_irq(core_irq), .irq(irq));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic stop_test;
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= a;
        do @(posedge mclk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hrdy !== 1'b1);
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] m, e);
        ahb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        idle(2);
        ev <= 6'h00;
        idle(5);
    endtask
    task automatic t_regs;
        logic [7:0] p [3] = '{8'h7F, 8'h25, 8'h00};
        rdc(A_E1, 32'hFFFFFFFF, 32'h0);
        rdc(A_F2, 32'hFFFFFFFF, 32'h0);
        rdc(A_G, 32'hFFFFFFFE, 32'h0);
        for (int k = 0; k < 3; k++) begin
            ahb(1'b1, A_E1, {24'hFFFFFF, p[k]});
            rdc(A_E1, 32'hFFFFFFFF, {24'h0, p[k]});
        end
        for (int k = 0; k < 4; k++) begin
            ahb(1'b1, 32'h2C + k * 32'h200, 32'h08 << k);
            for (int j = 0; j < 4; j++)
                rdc(32'h2C + j * 32'h200, 32'hF8, 32'h08 << k);
        end
    endtask
    task automatic t_flags;
        logic [7:0] b [6] = '{8'h01, 8'h02, 8'h04, 8'h80, 8'h08, 8'h01};
        ahb(1'b1, A_G, 32'h0);
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            rdc(i < 3 ? A_G : A_F2, 32'hFF, {24'h0, b[i]});
            ahb(1'b1, i < 3 ? A_G : A_F2, 32'h0);
            rdc(i < 3 ? A_G : A_F2, 32'hFF, 32'h0);
        end
    endtask
    task automatic t_gate;
        pf1 <= 8'h01;
        ahb(1'b1, A_E1, 32'h01);
        ahb(1'b1, 32'h804, 32'h0F);
        ahb(1'b1, 32'h808, 32'h08);
        ahb(1'b1, A_G, 32'h80);
        idle(4);
        chk(core_irq, 1'b0);
        ahb(1'b1, A_G, 32'hC0);
        idle(4);
        chk({core_irq, irq}, 2'h3);
        ahb(1'b1, 32'h808, 32'h0);
        idle(2);
        chk(irq, 1'b0);
        rdc(32'h800, 32'h08, 32'h08);
        ahb(1'b1, A_G, 32'h40);
        idle(4);
        chk(core_irq, 1'b0);
        ahb(1'b1, 32'h804, 32'h08);
        rdc(32'h800, 32'h08, 32'h0);
        pf1 <= 8'h00;
    endtask
    task automatic t_warm;
        ahb(1'b1, A_E1, 32'h5A);
        ahb(1'b1, A_G, 32'hF8);
        pulse(0);
        pulse(2);
        warm_rst <= 1'b1;
        idle(1);
        warm_rst <= 1'b0;
        rdc(A_G, 32'hFF, 32'h01);
        rdc(A_E1, 32'hFF, 32'h5A);
        rst_n <= 1'b0;
        idle(1);
        rst_n <= 1'b1;
        rdc(A_E1, 32'hFF, 32'h0);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        stop_test;
    end
    initial begin
        {rst_n, warm_rst, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        pf1 = 8'h00;
        ev = 6'h00;
        idle(3);
        rst_n <= 1'b1;
        t_regs;
        t_flags;
        t_gate;
        t_warm;
        stop_test;
    end
endmodule
`default_nettype wire
